// ### verilog/i2cra_pkg.sv
// constants, encodings and timing of the two-wire register access link
// assumes both ends run on clk_sys at 40 MHz and share this package
// ****************************************************************
// Overview of operation
// ****************************************************************
// Overview of operation
// - data stable while clock high; changes abort
// - bytes are eight bits, msb first, acked
// - start and stop are data edges, clock high
// - bus busy from start until stop
// - repeated start begins a new address phase
// - ninth clock: receiver pulls data low; device leaves it high for a data byte when its write buffer is full
// - reading master leaves last ack high
// - address pins select write address 60h-66h
// - seven address bits, then direction bit
// - ack only own address, else ignore
// - write: address, register pointer, data bytes
// - pointer steps by one per written byte
// - read: set pointer, repeated start, read
// - master ack steps pointer, sends next byte
package i2cra_pkg;

   // ****************************************************************
   // addressing
   // ****************************************************************
   localparam logic [7:0] WRITE_ADDR_BASE = 8'h60;
   localparam logic [3:0] BYTE_BITS       = 4'h8;
   localparam logic [7:0] RELEASED_BYTE   = 8'hFF;
   localparam logic [7:0] PTR_RESET       = 8'h00;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int         SYS_CLK_PERIOD_NS  = 25;
   localparam int         SCL_QUARTER_NS     = 625;
   localparam logic [7:0] SCL_QUARTER_CYCLES =
      8'((SCL_QUARTER_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

   // ****************************************************************
   // device phases and master steps
   // ****************************************************************
   localparam logic [1:0] PH_ADDR = 2'h0;
   localparam logic [1:0] PH_REG  = 2'h1;
   localparam logic [1:0] PH_DATA = 2'h2;
   localparam logic [1:0] PH_READ = 2'h3;

   localparam logic [1:0] STEP_DEV  = 2'h0;
   localparam logic [1:0] STEP_REG  = 2'h1;
   localparam logic [1:0] STEP_DATA = 2'h2;
   localparam logic [1:0] STEP_RECV = 2'h3;

   typedef enum logic [4:0] {
      S_IDLE   = 5'b0_0001,
      S_RX     = 5'b0_0010,
      S_RX_ACK = 5'b0_0100,
      S_TX     = 5'b0_1000,
      S_TX_ACK = 5'b1_0000
   } i2cra_slave_state_type;

   typedef enum logic [3:0] {
      M_IDLE  = 4'b0001,
      M_START = 4'b0010,
      M_BIT   = 4'b0100,
      M_STOP  = 4'b1000
   } i2cra_master_state_type;

endpackage

// ### verilog/i2cra_if.sv
// two-wire link between the register access master and the device
// assumes open-drain wires with pull-ups; enables high pull the wire low
`timescale 1ns/1ps
interface i2cra_if;
   logic scl_oe;
   logic scl_o;
   logic sda_m_oe;
   logic sda_m_o;
   logic sda_s_oe;
   logic sda_s_o;
   logic scl;
   logic sda;

   // ****************************************************************
   // wired-and resolution with pull-up
   // ****************************************************************
   assign scl = ~(scl_oe & ~scl_o);
   assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

   modport host   (output scl_oe, scl_o, sda_m_oe, sda_m_o, input scl, sda);
   modport device (output sda_s_oe, sda_s_o, input scl, sda);
endinterface

// ### verilog/i2cra_buf2.sv
// two-entry buffer with valid/ready on both sides
// assumes one clock domain for filling and draining
`timescale 1ns/1ps
module i2cra_buf2 #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   logic [WIDTH-1:0] mem_q [2];
   logic [WIDTH-1:0] mem_d [2];
   logic [1:0]       cnt_q;
   logic [1:0]       cnt_d;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = mem_q[0];

   always_comb begin
      push     = in_valid & in_ready;
      pop      = out_valid & out_ready;
      mem_d[0] = mem_q[0];
      mem_d[1] = mem_q[1];
      cnt_d    = cnt_q;
      if (pop) begin
         mem_d[0] = mem_q[1];
      end
      if (push) begin
         if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
            mem_d[0] = in_data;
         end else begin
            mem_d[1] = in_data;
         end
      end
      cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         cnt_q    <= 2'h0;
      end else begin
         mem_q[0] <= mem_d[0];
         mem_q[1] <= mem_d[1];
         cnt_q    <= cnt_d;
      end
   end
endmodule

// ### verilog/i2cra_slave.sv
// device end: two-wire slave giving access to 8-bit registers
// assumes the register store answers reg_rdata in the cycle after rd_req
`timescale 1ns/1ps
module i2cra_slave
   import i2cra_pkg::*;
(
   input  wire logic  clk_sys,
   input  wire logic  rst_n,
   i2cra_if.device    bus,
   input  wire logic  slave_address_select_low_pin,
   input  wire logic  slave_address_select_high_pin,
   output logic       bus_busy,
   output logic [7:0] reg_addr,
   output logic       rd_req,
   input  wire logic [7:0] reg_rdata,
   output logic       wr_valid,
   input  wire logic  wr_ready,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data
);
   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [3:0] meta_q;
   logic [3:0] sync_q;
   logic       scl_p_q;
   logic       sda_p_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_q  <= 4'h3;
         sync_q  <= 4'h3;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         meta_q  <= {slave_address_select_high_pin, slave_address_select_low_pin,
                     bus.sda, bus.scl};
         sync_q  <= meta_q;
         scl_p_q <= sync_q[0];
         sda_p_q <= sync_q[1];
      end
   end

   logic       scl_s;
   logic       sda_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_seen;
   logic       stop_seen;
   logic [6:0] own_addr;

   assign scl_s      = sync_q[0];
   assign sda_s      = sync_q[1];
   assign scl_rise   = scl_s & ~scl_p_q;
   assign scl_fall   = ~scl_s & scl_p_q;
   assign start_seen = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_seen  = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign own_addr   = WRITE_ADDR_BASE[7:1] | {5'h00, sync_q[3:2]};

   // ****************************************************************
   // write buffer toward the register store
   // ****************************************************************
   logic push;
   logic buf_ready;
   logic [15:0] buf_out;

   // ****************************************************************
   // protocol engine
   // ****************************************************************
   i2cra_slave_state_type state_q;
   i2cra_slave_state_type state_d;
   logic [3:0] bit_cnt_q;
   logic [3:0] bit_cnt_d;
   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic [7:0] tx_q;
   logic [7:0] tx_d;
   logic [7:0] ptr_q;
   logic [7:0] ptr_d;
   logic [1:0] phase_q;
   logic [1:0] phase_d;
   logic       ack_q;
   logic       ack_d;
   logic       sda_oe_q;
   logic       sda_oe_d;
   logic       busy_q;
   logic       busy_d;
   logic       rd_req_q;
   logic       rd_req_d;
   logic       load_q;
   logic       load_d;

   always_comb begin
      state_d   = state_q;
      bit_cnt_d = bit_cnt_q;
      shift_d   = shift_q;
      tx_d      = tx_q;
      ptr_d     = ptr_q;
      phase_d   = phase_q;
      ack_d     = ack_q;
      sda_oe_d  = sda_oe_q;
      busy_d    = busy_q;
      rd_req_d  = 1'b0;
      load_d    = rd_req_q;
      push      = 1'b0;
      if (load_q) begin
         tx_d = reg_rdata;
      end
      if (start_seen) begin
         busy_d = 1'b1;
      end else if (stop_seen) begin
         busy_d = 1'b0;
      end
      case (state_q)
         S_IDLE: begin
            sda_oe_d = 1'b0;
         end
         S_RX: begin
            if (scl_rise) begin
               shift_d   = {shift_q[6:0], sda_s};
               bit_cnt_d = 4'(bit_cnt_q + 4'h1);
            end else if (scl_fall && bit_cnt_q == BYTE_BITS) begin
               state_d  = S_RX_ACK;
               sda_oe_d = 1'b1;
               case (phase_q)
                  PH_ADDR: begin
                     if (shift_q[7:1] == own_addr) begin
                        phase_d  = shift_q[0] ? PH_READ : PH_REG;
                        rd_req_d = shift_q[0];
                     end else begin
                        state_d  = S_IDLE;
                        sda_oe_d = 1'b0;
                     end
                  end
                  PH_REG: begin
                     ptr_d   = shift_q;
                     phase_d = PH_DATA;
                  end
                  default: begin
                     push     = 1'b1;
                     sda_oe_d = buf_ready;
                     if (buf_ready) begin
                        ptr_d = 8'(ptr_q + 8'h01);
                     end
                  end
               endcase
            end
         end
         S_RX_ACK: begin
            if (scl_fall) begin
               bit_cnt_d = 4'h0;
               if (phase_q == PH_READ) begin
                  state_d  = S_TX;
                  sda_oe_d = ~tx_q[7];
                  tx_d     = {tx_q[6:0], 1'b0};
               end else begin
                  state_d  = S_RX;
                  sda_oe_d = 1'b0;
               end
            end
         end
         S_TX: begin
            if (scl_rise) begin
               bit_cnt_d = 4'(bit_cnt_q + 4'h1);
            end else if (scl_fall) begin
               if (bit_cnt_q == BYTE_BITS) begin
                  state_d  = S_TX_ACK;
                  sda_oe_d = 1'b0;
               end else begin
                  sda_oe_d = ~tx_q[7];
                  tx_d     = {tx_q[6:0], 1'b0};
               end
            end
         end
         S_TX_ACK: begin
            if (scl_rise) begin
               ack_d = ~sda_s;
               if (!sda_s) begin
                  ptr_d    = 8'(ptr_q + 8'h01);
                  rd_req_d = 1'b1;
               end
            end else if (scl_fall) begin
               bit_cnt_d = 4'h0;
               if (ack_q) begin
                  state_d  = S_TX;
                  sda_oe_d = ~tx_q[7];
                  tx_d     = {tx_q[6:0], 1'b0};
               end else begin
                  state_d = S_IDLE;
               end
            end
         end
         default: begin
            state_d  = S_IDLE;
            sda_oe_d = 1'b0;
         end
      endcase
      if (stop_seen) begin
         state_d  = S_IDLE;
         sda_oe_d = 1'b0;
      end else if (start_seen) begin
         sda_oe_d  = 1'b0;
         bit_cnt_d = 4'h0;
         phase_d   = PH_ADDR;
         // the clock rise just before a repeated start is counted as one bit
         if (state_q == S_IDLE || (state_q == S_RX && bit_cnt_q <= 4'h1)) begin
            state_d = S_RX;
         end else begin
            state_d = S_IDLE;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= S_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q   <= 8'h00;
         tx_q      <= 8'h00;
         ptr_q     <= PTR_RESET;
         phase_q   <= PH_ADDR;
         ack_q     <= 1'b0;
         sda_oe_q  <= 1'b0;
         busy_q    <= 1'b0;
         rd_req_q  <= 1'b0;
         load_q    <= 1'b0;
      end else begin
         state_q   <= state_d;
         bit_cnt_q <= bit_cnt_d;
         shift_q   <= shift_d;
         tx_q      <= tx_d;
         ptr_q     <= ptr_d;
         phase_q   <= phase_d;
         ack_q     <= ack_d;
         sda_oe_q  <= sda_oe_d;
         busy_q    <= busy_d;
         rd_req_q  <= rd_req_d;
         load_q    <= load_d;
      end
   end

   i2cra_buf2 #(
      .WIDTH (16)
   ) u_wbuf (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (buf_ready),
      .in_data   ({ptr_q, shift_q}),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (buf_out)
   );

   // ****************************************************************
   // outputs; clock is only ever read, never held low
   // ****************************************************************
   assign wr_addr      = buf_out[15:8];
   assign wr_data      = buf_out[7:0];
   assign reg_addr     = ptr_q;
   assign rd_req       = rd_req_q;
   assign bus_busy     = busy_q;
   assign bus.sda_s_oe = sda_oe_q;
   assign bus.sda_s_o  = 1'b0;
endmodule

// ### verilog/i2cra_master.sv
// host end: two-wire master doing single register writes and reads
// assumes one command at a time; scl is made here by a divider
`timescale 1ns/1ps
module i2cra_master
   import i2cra_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   i2cra_if.host           bus,
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic       cmd_read,
   input  wire logic [6:0] cmd_dev_addr,
   input  wire logic [7:0] cmd_reg,
   input  wire logic [7:0] cmd_wdata,
   output logic            rsp_valid,
   output logic            rsp_nack,
   output logic [7:0]      rsp_rdata
);
   logic sda_meta_q;
   logic sda_s_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sda_meta_q <= 1'b1;
         sda_s_q    <= 1'b1;
      end else begin
         sda_meta_q <= bus.sda;
         sda_s_q    <= sda_meta_q;
      end
   end

   // ****************************************************************
   // sequencer
   // ****************************************************************
   i2cra_master_state_type state_q;
   i2cra_master_state_type state_d;
   logic [7:0] div_q;
   logic [7:0] div_d;
   logic [1:0] qtr_q;
   logic [1:0] qtr_d;
   logic [3:0] bit_q;
   logic [3:0] bit_d;
   logic [1:0] step_q;
   logic [1:0] step_d;
   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic [6:0] dev_q;
   logic [6:0] dev_d;
   logic [7:0] reg_q;
   logic [7:0] reg_d;
   logic [7:0] wdata_q;
   logic [7:0] wdata_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       read_q;
   logic       read_d;
   logic       nack_q;
   logic       nack_d;
   logic       scl_oe_q;
   logic       scl_oe_d;
   logic       sda_oe_q;
   logic       sda_oe_d;
   logic       rsp_q;
   logic       rsp_d;
   logic       tick;

   function automatic logic [7:0] frame_byte(input logic [1:0] step, input logic rd,
                                             input logic [6:0] dev, input logic [7:0] rg,
                                             input logic [7:0] wd);
      case (step)
         STEP_DEV:  frame_byte = {dev, 1'b0};
         STEP_REG:  frame_byte = rg;
         STEP_DATA: frame_byte = rd ? {dev, 1'b1} : wd;
         default:   frame_byte = RELEASED_BYTE;
      endcase
   endfunction

   always_comb begin
      state_d   = state_q;
      div_d     = div_q;
      qtr_d     = qtr_q;
      bit_d     = bit_q;
      step_d    = step_q;
      shift_d   = shift_q;
      dev_d     = dev_q;
      reg_d     = reg_q;
      wdata_d   = wdata_q;
      rdata_d   = rdata_q;
      read_d    = read_q;
      nack_d    = nack_q;
      scl_oe_d  = scl_oe_q;
      sda_oe_d  = sda_oe_q;
      rsp_d     = 1'b0;
      cmd_ready = (state_q == M_IDLE);
      tick      = (div_q == 8'(SCL_QUARTER_CYCLES - 8'h01));
      if (state_q != M_IDLE) begin
         div_d = tick ? 8'h00 : 8'(div_q + 8'h01);
         if (tick) begin
            qtr_d = 2'(qtr_q + 2'h1);
         end
      end
      case (state_q)
         M_IDLE: begin
            scl_oe_d = 1'b0;
            sda_oe_d = 1'b0;
            if (cmd_valid) begin
               state_d = M_START;
               div_d   = 8'h00;
               qtr_d   = 2'h0;
               step_d  = STEP_DEV;
               dev_d   = cmd_dev_addr;
               reg_d   = cmd_reg;
               wdata_d = cmd_wdata;
               read_d  = cmd_read;
               nack_d  = 1'b0;
            end
         end
         M_START: begin
            if (tick) begin
               case (qtr_q)
                  2'h0: sda_oe_d = 1'b0;
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b1;
                  default: begin
                     scl_oe_d = 1'b1;
                     state_d  = M_BIT;
                     bit_d    = 4'h0;
                     shift_d  = frame_byte(step_q, read_q, dev_q, reg_q, wdata_q);
                  end
               endcase
            end
         end
         M_BIT: begin
            if (tick) begin
               case (qtr_q)
                  2'h0: sda_oe_d = (bit_q < BYTE_BITS) & ~shift_q[7];
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: begin
                     if (bit_q < BYTE_BITS) begin
                        shift_d = {shift_q[6:0], sda_s_q};
                     end else if (step_q != STEP_RECV) begin
                        nack_d = sda_s_q;
                     end
                  end
                  default: begin
                     scl_oe_d = 1'b1;
                     if (bit_q < BYTE_BITS) begin
                        bit_d = 4'(bit_q + 4'h1);
                     end else if (nack_q || step_q == STEP_RECV ||
                                  (step_q == STEP_DATA && !read_q)) begin
                        state_d = M_STOP;
                        rdata_d = shift_q;
                     end else if (step_q == STEP_REG && read_q) begin
                        step_d = STEP_DATA;
                        state_d = M_START;
                     end else begin
                        step_d  = 2'(step_q + 2'h1);
                        bit_d   = 4'h0;
                        shift_d = frame_byte(2'(step_q + 2'h1), read_q, dev_q, reg_q,
                                             wdata_q);
                     end
                  end
               endcase
            end
         end
         M_STOP: begin
            if (tick) begin
               case (qtr_q)
                  2'h0: sda_oe_d = 1'b1;
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b0;
                  default: begin
                     state_d = M_IDLE;
                     rsp_d   = 1'b1;
                  end
               endcase
            end
         end
         default: begin
            state_d = M_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= M_IDLE;
         div_q    <= 8'h00;
         qtr_q    <= 2'h0;
         bit_q    <= 4'h0;
         step_q   <= STEP_DEV;
         shift_q  <= 8'h00;
         dev_q    <= 7'h00;
         reg_q    <= 8'h00;
         wdata_q  <= 8'h00;
         rdata_q  <= 8'h00;
         read_q   <= 1'b0;
         nack_q   <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         rsp_q    <= 1'b0;
      end else begin
         state_q  <= state_d;
         div_q    <= div_d;
         qtr_q    <= qtr_d;
         bit_q    <= bit_d;
         step_q   <= step_d;
         shift_q  <= shift_d;
         dev_q    <= dev_d;
         reg_q    <= reg_d;
         wdata_q  <= wdata_d;
         rdata_q  <= rdata_d;
         read_q   <= read_d;
         nack_q   <= nack_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         rsp_q    <= rsp_d;
      end
   end

   assign bus.scl_oe   = scl_oe_q;
   assign bus.scl_o    = 1'b0;
   assign bus.sda_m_oe = sda_oe_q;
   assign bus.sda_m_o  = 1'b0;
   assign rsp_valid    = rsp_q;
   assign rsp_nack     = nack_q;
   assign rsp_rdata    = rdata_q;
endmodule

// ### tb/i2cra_link_monitor.sv
// checker: timing and ownership rules on the two-wire link
// assumes the link signals as plain inputs, all in clk_sys
`timescale 1ns/1ps
module i2cra_link_monitor (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic scl_oe,
   input wire logic scl_o,
   input wire logic sda_m_oe,
   input wire logic sda_m_o,
   input wire logic sda_s_oe,
   input wire logic sda_s_o,
   input wire logic scl,
   input wire logic sda
);
   logic       scl_q, sda_q, start_c, stop_c;
   logic [3:0] rises_q, rises_d;
   // ********
   // frame tracking
   // ********
   assign start_c = scl & scl_q & sda_q & ~sda;
   assign stop_c  = scl & scl_q & ~sda_q & sda;
   always_comb begin
      rises_d = rises_q;
      if (start_c) begin
         rises_d = 4'h0;
      end else if (scl & ~scl_q & (rises_q != 4'hf)) begin
         rises_d = rises_q + 4'h1;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
         rises_q <= 4'h0;
      end else begin
         scl_q   <= scl;
         sda_q   <= sda;
         rises_q <= rises_d;
      end
   end
   // ********
   // assertions
   // ********
   default clocking mon_cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_dev_stable_high: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
      else $error("device moved data while clock high");
   chk_start_by_host: assert property (start_c |-> $rose(sda_m_oe))
      else $error("start not made by host");
   chk_stop_by_host: assert property (stop_c |-> $fell(sda_m_oe))
      else $error("stop not made by host");
   chk_stop_frees_data: assert property (stop_c |-> !sda_s_oe [*8])
      else $error("device holds data after stop");
   chk_clock_high_min: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
   chk_clock_low_min: assert property ($fell(scl) |-> !scl [*8])
      else $error("clock low phase too short");
   chk_address_quiet: assert property (rises_q < 4'h8 |-> !sda_s_oe)
      else $error("device drives during address bits");
   chk_ack_held_high: assert property ($rose(scl) && sda_s_oe |-> sda_s_oe [*8])
      else $error("acknowledge dropped in clock high");
   cover property (start_c);
   cover property (stop_c);
   cover property ($rose(scl) && rises_q == 4'h8 && sda_s_oe);
endmodule

// ### tb/i2c_register_access_slave_tb.sv
// bench: host end and device end joined over one link
// assumes package, interface and both ends are compiled first
`timescale 1ns/1ps
module i2c_register_access_slave_tb;
   import i2cra_pkg::*;
   logic        clk_sys, rst_n, cmd_valid, cmd_ready, cmd_read, rsp_valid, rsp_nack;
   logic        pin_lo, pin_hi, bus_busy, rd_req, wr_valid, wr_ready, stall;
   logic [6:0]  cmd_dev_addr;
   logic [7:0]  cmd_reg, cmd_wdata, rsp_rdata, reg_addr, reg_rdata, wr_addr, wr_data, r;
   logic [7:0]  mem [256] = '{default: 8'h00};
   logic [7:0]  shadow [256] = '{default: 8'h00};
   logic [31:0] seed = 32'hbe75_1ab9;
   logic [15:0] wq [$];
   logic [9:0]  rq [$];
   logic [9:0]  e;
   int          fail_count = 0;
   int          compares = 0;
   i2cra_if link ();
   i2cra_master i_i2cra_master (.clk_sys(clk_sys), .rst_n(rst_n), .bus(link.host),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
      .cmd_dev_addr(cmd_dev_addr), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata),
      .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata));
   i2cra_slave i_i2cra_slave (.clk_sys(clk_sys), .rst_n(rst_n), .bus(link.device),
      .slave_address_select_low_pin(pin_lo), .slave_address_select_high_pin(pin_hi),
      .bus_busy(bus_busy), .reg_addr(reg_addr), .rd_req(rd_req), .reg_rdata(reg_rdata),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data));
   i2cra_link_monitor i_i2cra_link_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
      .scl_oe(link.scl_oe), .scl_o(link.scl_o), .sda_m_oe(link.sda_m_oe),
      .sda_m_o(link.sda_m_o), .sda_s_oe(link.sda_s_oe), .sda_s_o(link.sda_s_o),
      .scl(link.scl), .sda(link.sda));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t word got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cmp_rsp(input logic [9:0] got, input logic [9:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t response got %h want %h", $time, got, exp);
      end
   endtask
   // ********
   // one host command, noted then waited for
   // ********
   task automatic do_cmd(input logic rd, input logic [6:0] dev, input logic [7:0] rg,
                         input logic [7:0] wd, input logic nk);
      int n;
      rq.push_back({rd, nk, rd ? shadow[rg] : 8'h00});
      if (!rd && !nk) begin
         wq.push_back({rg, wd});
         shadow[rg] = wd;
      end
      n = 0;
      while (cmd_ready !== 1'b1 && n < 9000) begin
         @(negedge clk_sys);
         n++;
      end
      {cmd_read, cmd_dev_addr, cmd_reg, cmd_wdata, cmd_valid} = {rd, dev, rg, wd, 1'b1};
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      repeat (300) @(negedge clk_sys);
      cmp_word({15'h0000, bus_busy}, 16'h0001);
      while (rsp_valid !== 1'b1 && n < 9000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 9000) begin
         fail_count++;
         conclude();
      end
      @(negedge clk_sys);
      cmp_word({15'h0000, bus_busy}, 16'h0000);
      if (!nk) cmp_word({8'h00, reg_addr}, {8'h00, rd ? rg : rg + 8'h01});
   endtask
   // ********
   // register store, consumer and result watcher
   // ********
   always @(posedge clk_sys) begin
      if (rd_req === 1'b1) reg_rdata <= mem[reg_addr];
      if (rst_n === 1'b1 && wr_valid === 1'b1 && wr_ready === 1'b1) begin
         cmp_word({wr_addr, wr_data}, wq.size() > 0 ? wq.pop_front() : 16'hxxxx);
         mem[wr_addr] <= wr_data;
      end
      if (rst_n === 1'b1 && rsp_valid === 1'b1) begin
         e = rq.size() > 0 ? rq.pop_front() : 10'h3ff;
         cmp_rsp({e[9], rsp_nack, e[9] ? rsp_rdata : 8'h00}, e);
      end
   end
   always @(negedge clk_sys) begin
      seed = lfsr(seed);
      wr_ready = ~stall & seed[0];
   end
   initial begin
      {rst_n, cmd_valid, cmd_read, cmd_dev_addr, cmd_reg, cmd_wdata} = '0;
      {pin_lo, pin_hi, stall} = '0;
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      for (int p = 0; p < 4; p++) begin
         {pin_hi, pin_lo} = 2'(p);
         repeat (4) @(negedge clk_sys);
         r = seed[15:8];
         do_cmd(1'b0, 7'h30 | 7'(p), r, seed[7:0], 1'b0);
         do_cmd(1'b1, 7'h30 | 7'(p), r, 8'h00, 1'b0);
         do_cmd(1'b0, 7'h30 | 7'((p + 1) % 4), r, 8'h5a, 1'b1);
         $display("test address select %0d done", p);
      end
      do_cmd(1'b0, 7'h33, 8'hff, seed[7:0], 1'b0);
      do_cmd(1'b1, 7'h33, 8'hff, 8'h00, 1'b0);
      $display("test pointer wrap done");
      stall = 1'b1;
      for (int i = 0; i < 3; i++) do_cmd(1'b0, 7'h33, 8'(8'h10 + i), seed[7:0], i == 2);
      stall = 1'b0;
      repeat (40) @(negedge clk_sys);
      cmp_word(16'(wq.size()), 16'h0000);
      do_cmd(1'b1, 7'h33, 8'h11, 8'h00, 1'b0);
      $display("test full buffer done");
      conclude();
   end
endmodule
